// ==== common/apcc_cfg.svh ====
/*
 * Constants of the axis position capture / compare block: register
 * offsets, field positions, reset values and timing figures.
 * Assumes a 10 MHz mclk and an APB master with 32-bit data.
 */
// How it works
// - rising capture edge latches selected axis position
// - capture store holds 1024 positions
// - position loaded within 100 ns of edge
// - capture input fixed active high, no invert
// - nonzero target arms; done at bit 5; zero disables
// - captured count readable; stored positions readable
// - two compare outputs assert at compare position
// - compare list up to 1024, length configurable
// - arming aborts compare and resets index to 0
// - on equality assert output, load next entry
// - all compare events done sets done flag
// - length 1 plus increment gives incremental compare
// - host spaces compare events one tick apart
// - output activates within 100 ns of match
// - disabled mode holds output low
// - invert option swaps output active level
// - pulse width 1 ms to 1 s, stepped
// - latch mode stays on until next command
// - flip mode toggles output every event
// - reset leaves output mode disabled
// - compare tally readable; disable command stops compare
`ifndef APCC_CFG_SVH
`define APCC_CFG_SVH
`define APCC_DEPTH        11'd1024
`define APCC_OFS_CMP_CFG   8'h00
`define APCC_OFS_CMP_CTL   8'h04
`define APCC_OFS_CMP_INC   8'h08
`define APCC_OFS_CMP_WID   8'h0C
`define APCC_OFS_CAP_TGT   8'h10
`define APCC_OFS_STATUS    8'h14
`define APCC_OFS_CAP_TALLY 8'h18
`define APCC_OFS_CMP_TALLY 8'h1C
`define APCC_OFS_CAP_IDX   8'h20
`define APCC_OFS_CAP_DATA  8'h24
`define APCC_OFS_CMP_IDX   8'h28
`define APCC_OFS_CMP_DATA  8'h2C
`define APCC_CFG_INV0      3
`define APCC_CFG_INV1      4
`define APCC_CFG_OPEN      5
`define APCC_CFG_LEN_LSB   16
`define APCC_CTL_ARM       0
`define APCC_CTL_OFF       1
`define APCC_ST_CAP_DONE   5
`define APCC_ST_CMP_DONE   6
`define APCC_RST_MODE      3'h0
`define APCC_RST_LEN       11'h001
`define APCC_RST_WID       10'h001
`define APCC_CLK_NS        100
`define APCC_MS_NS         1000000
`define APCC_STEP_MS       10'd50
`define APCC_MAX_MS        10'd1000
`endif

// ==== common/apcc_pkg.sv ====
/*
 * Types of the axis position capture / compare block.
 * Assumes apcc_cfg.svh is on the include path.
 */
`default_nettype none
package apcc_pkg;
	typedef enum logic [2:0] {
		APCC_OUT_NONE  = 3'b000,
		APCC_OUT_PULSE = 3'b001,
		APCC_OUT_LATCH = 3'b010,
		APCC_OUT_FLIP  = 3'b011
	} apcc_mode_t;
	typedef struct packed {
		logic        capS1, capS2, capS3;
		logic [31:0] posD1, posD2;
		logic [10:0] capTarget, capTally;
		logic        captureDoneFlag;
		logic [9:0]  capRdIdx;
		logic [2:0]  cmpMode;
		logic [1:0]  compareOutInvert;
		logic        openLoop;
		logic [10:0] cmpLen;
		logic [31:0] cmpInc;
		logic [9:0]  cmpWidth;
		logic        cmpActive;
		logic [10:0] cmpIdx;
		logic [31:0] cmpTarget, cmpTally;
		logic        cmpLevel;
		logic [9:0]  pulseMs;
		logic [13:0] prescale;
		logic        compareDoneFlag;
		logic [9:0]  cmpWrIdx;
		logic [31:0] prdata;
		logic        slvErr;
		logic [1:0]  pins;
	} apcc_state_t;
endpackage
`default_nettype wire

// ==== design/apcc_top.sv ====
/*
 * One axis of position capture and position compare, with an APB slave.
 * Assumes encoder and step counts come from logic on mclk; the capture
 * pin is asynchronous to mclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "apcc_cfg.svh"
module apcc_top #(
	parameter int MS_CYCLES = `APCC_MS_NS / `APCC_CLK_NS
) (
	input  wire logic        mclk,         // 10 MHz clock
	input  wire logic        sys_rst,      // synchronous reset
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb access phase
	input  wire logic        pwrite,       // apb direction
	input  wire logic [7:0]  paddr,        // apb byte address
	input  wire logic [31:0] pwdata,       // apb write data
	output logic      [31:0] prdata,       // apb read data
	output logic             pready,       // apb ready
	output logic             pslverr,      // apb error, unmapped
	input  wire logic [31:0] encoderCount, // closed-loop position
	input  wire logic [31:0] stepCount,    // open-loop step count
	input  wire logic        captureIn,    // capture pin, async
	output logic      [1:0]  compareOut    // compare pins
);
	import apcc_pkg::*;

	apcc_state_t s, n;
	logic [31:0] capMem [0:1023];
	logic [31:0] cmpList [0:1023];

	logic        setup, acc, wr, rd, mapped;
	logic        capRise, capStore, capWr, capSet;
	logic        armWr, offWr, listWr;
	logic        cmpHit, incMode, lastHit, cmpSet;
	logic [31:0] pos;
	logic [31:0] rdMux;
	logic [10:0] nextIdx;

	// widths above the step round down to a whole step
	function automatic logic [9:0] effWidth(input logic [9:0] w);
		logic [9:0] c;
		c = (w == 10'h000) ? 10'h001 : w;
		if (c > `APCC_MAX_MS)
			c = `APCC_MAX_MS;
		if (c > `APCC_STEP_MS)
			c = c - (c % `APCC_STEP_MS);
		return c;
	endfunction

	function automatic logic isReg(input logic [7:0] a,
		input logic [7:0] ofs);
		return a == ofs;
	endfunction

	assign pready  = 1'b1;
	assign prdata  = s.prdata;
	assign pslverr = s.slvErr;
	assign compareOut = s.pins;

	assign setup = psel && !penable;
	assign acc   = psel && penable;
	assign wr    = acc && pwrite;
	assign rd    = acc && !pwrite;

	assign pos = s.openLoop ? stepCount : encoderCount;

	always_comb begin
		mapped = 1'b1;
		rdMux = 32'h0000_0000;
		unique case (paddr)
			`APCC_OFS_CMP_CFG: rdMux = {5'h00, s.cmpLen, 10'h000,
				s.openLoop, s.compareOutInvert, s.cmpMode};
			`APCC_OFS_CMP_CTL: rdMux = {31'h0000_0000, s.cmpActive};
			`APCC_OFS_CMP_INC: rdMux = s.cmpInc;
			`APCC_OFS_CMP_WID: rdMux = {22'h00_0000, s.cmpWidth};
			`APCC_OFS_CAP_TGT: rdMux = {21'h00_0000, s.capTarget};
			`APCC_OFS_STATUS: rdMux = {21'h00_0000, s.pins,
				s.capTarget != 11'h000, s.cmpActive,
				s.compareDoneFlag, s.captureDoneFlag, 5'h00};
			`APCC_OFS_CAP_TALLY: rdMux = {21'h00_0000, s.capTally};
			`APCC_OFS_CMP_TALLY: rdMux = s.cmpTally;
			`APCC_OFS_CAP_IDX: rdMux = {22'h00_0000, s.capRdIdx};
			`APCC_OFS_CAP_DATA: rdMux = capMem[s.capRdIdx];
			`APCC_OFS_CMP_IDX: rdMux = {22'h00_0000, s.cmpWrIdx};
			`APCC_OFS_CMP_DATA: rdMux = cmpList[s.cmpWrIdx];
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		n = s;
		capWr  = wr && isReg(paddr, `APCC_OFS_CAP_TGT);
		armWr  = wr && isReg(paddr, `APCC_OFS_CMP_CTL)
			&& pwdata[`APCC_CTL_ARM];
		offWr  = wr && isReg(paddr, `APCC_OFS_CMP_CTL)
			&& pwdata[`APCC_CTL_OFF] && !pwdata[`APCC_CTL_ARM];
		listWr = wr && isReg(paddr, `APCC_OFS_CMP_DATA);

		// bus: read data and error are taken in the setup cycle so
		// the access phase can finish with no wait state
		if (setup) begin
			n.prdata = rdMux;
			n.slvErr = !mapped;
		end
		if (wr) begin
			unique case (paddr)
				`APCC_OFS_CMP_CFG: begin
					n.cmpMode = pwdata[2:0];
					n.compareOutInvert = {pwdata[`APCC_CFG_INV1],
						pwdata[`APCC_CFG_INV0]};
					n.openLoop = pwdata[`APCC_CFG_OPEN];
					n.cmpLen = pwdata[`APCC_CFG_LEN_LSB +: 11];
					if (n.cmpLen > `APCC_DEPTH)
						n.cmpLen = `APCC_DEPTH;
				end
				`APCC_OFS_CMP_INC: n.cmpInc = pwdata;
				`APCC_OFS_CMP_WID: n.cmpWidth = pwdata[9:0];
				`APCC_OFS_CAP_IDX: n.capRdIdx = pwdata[9:0];
				`APCC_OFS_CMP_IDX: n.cmpWrIdx = pwdata[9:0];
				`APCC_OFS_CMP_DATA: n.cmpWrIdx = s.cmpWrIdx + 10'h001;
				default: ;
			endcase
		end
		if (rd && isReg(paddr, `APCC_OFS_CAP_DATA))
			n.capRdIdx = s.capRdIdx + 10'h001;

		// capture: the pin passes two flops, so the position is
		// delayed by the same two stages to stay edge aligned
		n.capS1 = captureIn;
		n.capS2 = s.capS1;
		n.capS3 = s.capS2;
		n.posD1 = pos;
		n.posD2 = s.posD1;
		capRise = s.capS2 && !s.capS3;
		capStore = capRise && (s.capTarget != 11'h000)
			&& (s.capTally < s.capTarget);
		capSet = capStore && (s.capTally + 11'h001 == s.capTarget);
		if (capStore)
			n.capTally = s.capTally + 11'h001;
		if (capWr) begin
			n.capTarget = pwdata[10:0];
			if (pwdata[31:0] > 32'h0000_0400)
				n.capTarget = `APCC_DEPTH;
			n.capTally = 11'h000;
		end
		// a done event in the cycle of the rearm write still lands
		n.captureDoneFlag = (capWr ? 1'b0 : s.captureDoneFlag)
			| capSet;

		// compare
		incMode = (s.cmpLen == 11'h001) && (s.cmpInc != 32'h0000_0000);
		cmpHit  = s.cmpActive && (pos == s.cmpTarget);
		nextIdx = s.cmpIdx + 11'h001;
		lastHit = cmpHit && !incMode && (nextIdx >= s.cmpLen);
		cmpSet  = lastHit;
		if (s.cmpLevel && s.cmpMode == APCC_OUT_PULSE) begin
			if (s.prescale == 14'(MS_CYCLES - 1)) begin
				n.prescale = 14'h0000;
				n.pulseMs = s.pulseMs - 10'h001;
				if (s.pulseMs <= 10'h001)
					n.cmpLevel = 1'b0;
			end else begin
				n.prescale = s.prescale + 14'h0001;
			end
		end
		if (cmpHit) begin
			n.cmpTally = s.cmpTally + 32'h0000_0001;
			if (incMode)
				n.cmpTarget = s.cmpTarget + s.cmpInc;
			else if (lastHit)
				n.cmpActive = 1'b0;
			else begin
				// next target is ready at once; the host keeps events a
				// trajectory tick apart, so no tick input is needed
				n.cmpIdx = nextIdx;
				n.cmpTarget = cmpList[nextIdx[9:0]];
			end
			unique case (s.cmpMode)
				APCC_OUT_PULSE: begin
					n.cmpLevel = 1'b1;
					n.pulseMs = effWidth(s.cmpWidth);
					n.prescale = 14'h0000;
				end
				APCC_OUT_LATCH: n.cmpLevel = 1'b1;
				APCC_OUT_FLIP: n.cmpLevel = !s.cmpLevel;
				default: n.cmpLevel = 1'b0;
			endcase
		end
		if (offWr) begin
			n.cmpActive = 1'b0;
			n.cmpLevel = 1'b0;
		end
		if (armWr) begin
			n.cmpActive = s.cmpLen != 11'h000;
			n.cmpIdx = 11'h000;
			n.cmpTarget = cmpList[0];
			n.cmpTally = 32'h0000_0000;
			n.cmpLevel = 1'b0;
		end
		n.compareDoneFlag = (armWr ? 1'b0 : s.compareDoneFlag)
			| cmpSet;

		// one registered stage after the match: 100 ns at 10 MHz
		for (int i = 0; i < 2; i++) begin
			if (n.cmpMode == APCC_OUT_PULSE || n.cmpMode == APCC_OUT_LATCH
				|| n.cmpMode == APCC_OUT_FLIP)
				n.pins[i] = n.cmpLevel ^ n.compareOutInvert[i];
			else
				n.pins[i] = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s <= '0;
			s.cmpMode <= `APCC_RST_MODE;
			s.cmpLen <= `APCC_RST_LEN;
			s.cmpWidth <= `APCC_RST_WID;
		end else begin
			s <= n;
		end
	end

	// memories carry no reset; contents are undefined until written
	always_ff @(posedge mclk) begin
		if (!sys_rst && capStore)
			capMem[s.capTally[9:0]] <= s.posD2;
		if (!sys_rst && listWr)
			cmpList[s.cmpWrIdx] <= pwdata;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_cap_tally_step: assert property (
		capStore && !capWr |=> s.capTally == $past(s.capTally) + 11'h001)
		else $error("capture tally did not advance on edge");
	a_cap_store_bound: assert property (
		s.capTally == `APCC_DEPTH && !capWr |=> s.capTally == `APCC_DEPTH)
		else $error("full capture store changed");
	a_cap_store_max: assert property (
		s.capTally <= `APCC_DEPTH)
		else $error("capture tally beyond store depth");
	a_cap_done_set: assert property (
		capStore && !capWr && s.capTally + 11'h001 == s.capTarget
		|=> s.captureDoneFlag)
		else $error("capture done flag not set");
	a_cap_zero_off: assert property (
		s.capTarget == 11'h000 |-> !capStore)
		else $error("capture stored while disabled");
	a_cap_fall_ignored: assert property (
		!s.capS2 && s.capS3 |-> !capStore)
		else $error("capture taken on falling edge");
	a_cmp_arm_clear: assert property (
		armWr |=> s.cmpIdx == 11'h000 && s.cmpTally == 32'h0000_0000
		&& !s.cmpLevel)
		else $error("arm did not reset compare");
	a_cmp_latch_pin: assert property (
		cmpHit && s.cmpMode == APCC_OUT_LATCH && !armWr && !offWr
		&& !wr |=> compareOut == ~s.compareOutInvert)
		else $error("compare pin late after match");
	a_cmp_none_low: assert property (
		s.cmpMode == APCC_OUT_NONE |-> compareOut == 2'b00)
		else $error("disabled compare output not low");
	a_cmp_flip_event: assert property (
		cmpHit && s.cmpMode == APCC_OUT_FLIP && !armWr && !offWr && !wr
		|=> s.cmpLevel != $past(s.cmpLevel))
		else $error("flip mode did not toggle");
	a_cmp_last_done: assert property (
		lastHit && !armWr |=> s.compareDoneFlag && !s.cmpActive)
		else $error("compare done not flagged");
	a_cmp_inc_step: assert property (
		cmpHit && incMode && !armWr
		|=> s.cmpTarget == $past(s.cmpTarget) + $past(s.cmpInc))
		else $error("incremental target wrong");
	a_cmp_off_stop: assert property (
		offWr |=> !s.cmpActive ##1 !cmpHit)
		else $error("compare still active after off");

	c_cap_done: cover property (capSet);
	c_cmp_list_end: cover property (lastHit);
	c_cmp_pulse_end: cover property (
		s.cmpMode == APCC_OUT_PULSE ##0 $fell(s.cmpLevel));
	c_cmp_inc: cover property (cmpHit && incMode);
endmodule // apcc_top
`default_nettype wire

// ==== tb/apcc_trigger_src.sv ====
/*
 * Far-side model: an external trigger sensor on the capture pin.
 * Assumes the bench requests pulses with fire, one mclk cycle wide.
 */
`timescale 1ns/10ps
`default_nettype none
module apcc_trigger_src #(
	parameter int HIGH_CYC = 3,  // pin high time, beyond the sync stages
	parameter int MIN_GAP  = 20  // rise spacing, scaled-down rate limit
) (
	input  wire logic mclk,      // bench clock
	input  wire logic fire,      // request one trigger pulse
	output logic      captureIn, // capture pin, active high
	output logic      trigBusy   // pulse or spacing window open
);
	int cnt = 0;
	// a request inside the spacing window is dropped, never queued
	always @(posedge mclk) begin
		if (cnt == 0 && fire)
			cnt <= MIN_GAP;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	assign captureIn = (cnt > MIN_GAP - HIGH_CYC);
	assign trigBusy  = (cnt != 0);
endmodule // apcc_trigger_src
`default_nettype wire

// ==== tb/apcc_top_tb.sv ====
/*
 * Self-checking bench for apcc_top: APB register tasks, capture
 * triggers and position steps. Assumes apcc_cfg.svh on the include path.
 */
`timescale 1ns/10ps
`default_nettype none
`include "apcc_cfg.svh"
`define CHK(nm, exp, got) begin \
	testsRun++; \
	if ((got) !== (exp)) begin \
		nErrors++; \
		$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
	end \
end
module apcc_top_tb;
	import apcc_pkg::*;
	localparam int MS = 10; // short millisecond keeps pulse tests brief
	logic        mclk         = 1'b0;
	logic        sys_rst      = 1'b1;
	logic        psel         = 1'b0;
	logic        penable      = 1'b0;
	logic        pwrite       = 1'b0;
	logic [7:0]  paddr        = 8'h00;
	logic [31:0] pwdata       = 32'h0;
	logic [31:0] encoderCount = 32'h0;
	logic [31:0] stepCount    = 32'h0;
	logic        fire         = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, captureIn, trigBusy;
	logic [1:0]  compareOut;
	logic [31:0] q;
	logic        e;
	int          nErrors      = 0;
	int          testsRun     = 0;
	always #50 mclk = ~mclk;
	apcc_top #(.MS_CYCLES(MS)) apcc_top_i (.mclk(mclk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .encoderCount(encoderCount),
		.stepCount(stepCount), .captureIn(captureIn),
		.compareOut(compareOut));
	apcc_trigger_src apcc_trigger_src_i (.mclk(mclk), .fire(fire),
		.captureIn(captureIn), .trigBusy(trigBusy));
	task automatic give_verdict();
		$display("errors %0d checks %0d", nErrors, testsRun);
		if (nErrors == 0 && testsRun > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rq, output logic re);
		int n;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rq = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			nErrors++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rq;
		logic        re;
		apb(1'b1, a, d, rq, re);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x,
		input string nm);
		logic [31:0] rq;
		logic        re;
		apb(1'b0, a, 32'h0, rq, re);
		`CHK(nm, x, rq)
	endtask
	// pins are checked one edge after the position lands: 100 ns budget
	task automatic pos(input logic [31:0] p, input logic [1:0] pins,
		input string nm);
		@(posedge mclk);
		encoderCount <= p;
		@(posedge mclk);
		#10;
		`CHK(nm, pins, compareOut)
	endtask
	task automatic trig();
		int n;
		@(posedge mclk);
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		@(posedge mclk);
		// the pin edge is sampled now; moving the step count after it
		// shows whether the stored value predates the edge
		stepCount <= stepCount + 32'h0000_0001;
		for (n = 0; trigBusy === 1'b1 && n < 40; n++)
			@(posedge mclk);
		`CHK("trigger idle", 1'b0, trigBusy)
		if (trigBusy === 1'b1)
			give_verdict();
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		#10;
		`CHK("pins after reset", 2'b00, compareOut)
		rdc(`APCC_OFS_CMP_CFG, 32'h0001_0000, "cfg reset");
		rdc(`APCC_OFS_STATUS, 32'h0, "status reset");
		apb(1'b0, 8'hFC, 32'h0, q, e);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, q)
		wr(`APCC_OFS_CAP_TGT, 32'h2);
		pos(32'h0000_1234, 2'b00, "idle pins");
		trig();
		rdc(`APCC_OFS_CAP_TALLY, 32'h1, "cap tally");
		rdc(`APCC_OFS_STATUS, 32'h0000_0100, "armed");
		wr(`APCC_OFS_CMP_CFG, 32'h0001_0020);
		@(posedge mclk);
		stepCount <= 32'h0000_0ABC;
		trig();
		rdc(`APCC_OFS_STATUS, 32'h0000_0120, "cap done");
		trig();
		rdc(`APCC_OFS_CAP_TALLY, 32'h2, "full store");
		wr(`APCC_OFS_CAP_IDX, 32'h0);
		rdc(`APCC_OFS_CAP_DATA, 32'h0000_1234, "cap enc");
		rdc(`APCC_OFS_CAP_DATA, 32'h0000_0ABC, "cap step");
		wr(`APCC_OFS_CAP_TGT, 32'h0);
		rdc(`APCC_OFS_STATUS, 32'h0, "cap off");
		// two-entry list shared by the latch, flip and none runs
		wr(`APCC_OFS_CMP_IDX, 32'h0);
		wr(`APCC_OFS_CMP_DATA, 32'd100);
		wr(`APCC_OFS_CMP_DATA, 32'd200);
		wr(`APCC_OFS_CMP_CFG, {16'h0002, 13'h0, APCC_OUT_LATCH});
		wr(`APCC_OFS_CMP_CTL, 32'h1);
		pos(32'd100, 2'b11, "latch on");
		pos(32'd150, 2'b11, "latch hold");
		pos(32'd200, 2'b11, "latch last");
		rdc(`APCC_OFS_STATUS, 32'h0000_0640, "cmp done");
		rdc(`APCC_OFS_CMP_TALLY, 32'h2, "cmp tally");
		// a reset in mid-run drops the latched pins and the mode
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		#10;
		`CHK("pins mid reset", 2'b00, compareOut)
		rdc(`APCC_OFS_CMP_CFG, 32'h0001_0000, "cfg mid reset");
		wr(`APCC_OFS_CMP_CFG, {16'h0002, 13'h2, APCC_OUT_FLIP});
		wr(`APCC_OFS_CMP_CTL, 32'h1);
		pos(32'd150, 2'b10, "flip armed");
		pos(32'd100, 2'b01, "flip one");
		pos(32'd200, 2'b10, "flip two");
		wr(`APCC_OFS_CMP_WID, 32'h2);
		wr(`APCC_OFS_CMP_INC, 32'd10);
		wr(`APCC_OFS_CMP_CFG, {16'h0001, 13'h0, APCC_OUT_PULSE});
		wr(`APCC_OFS_CMP_CTL, 32'h1);
		pos(32'd100, 2'b11, "pulse start");
		// 2 ms of MS cycles each: the pins fall 20 edges after the event
		repeat (2 * MS - 1) @(posedge mclk);
		#10;
		`CHK("pulse mid", 2'b11, compareOut)
		@(posedge mclk);
		#10;
		`CHK("pulse end", 2'b00, compareOut)
		pos(32'd110, 2'b11, "incr step");
		wr(`APCC_OFS_CMP_CTL, 32'h2);
		pos(32'd120, 2'b00, "off");
		rdc(`APCC_OFS_CMP_TALLY, 32'h2, "off tally");
		wr(`APCC_OFS_CMP_CFG, {16'h0001, 13'h0, APCC_OUT_NONE});
		wr(`APCC_OFS_CMP_CTL, 32'h1);
		pos(32'd100, 2'b00, "none pins");
		rdc(`APCC_OFS_CMP_TALLY, 32'h1, "none tally");
		give_verdict();
	end
endmodule // apcc_top_tb
`default_nettype wire
